/* rtl/otg_control_consts.svh */
// Offsets, field positions and reset value of the OTG control register
`ifndef OTG_CONTROL_CONSTS_SVH
`define OTG_CONTROL_CONSTS_SVH

`define OTG_ADDR_WRITE      6'h0A
`define OTG_ADDR_SET        6'h0B
`define OTG_ADDR_CLEAR      6'h0C

`define OTG_BIT_EXT_FAULT   7
`define OTG_BIT_EXT_SUPPLY  6
`define OTG_BIT_DRIVE       5
`define OTG_BIT_CHARGE      4
`define OTG_BIT_DISCHARGE   3
`define OTG_BIT_MINUS_PD    2
`define OTG_BIT_PLUS_PD     1
`define OTG_BIT_ID_LINE_PULLUP_SAMPLE   0

`define OTG_RESET_VALUE     8'h06

`endif

/* rtl/otg_control_pkg.sv */
// Types shared by the OTG control register block
package otg_control_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] reg_addr_t;
  typedef enum logic [1:0] {
    ACC_WRITE,
    ACC_SET,
    ACC_CLEAR,
    ACC_NONE
  } access_kind_t;
endpackage : otg_control_pkg

/* rtl/otg_control_register.sv */
// OTG control register: bus power sourcing, sensing and data-line resistor control
// What this block does
// - Read 0Ah-0Ch; write 0Ah, set 0Bh, clear 0Ch
// - Bit 7 picks fault pin over comparator
// - Bit 6 selects external supply, drives switch low
// - Bit 5 drives 5 V bus power
// - Bit 4 connects charging resistor
// - Bit 3 connects discharge resistor
// - Bit 2 minus pull-down, reset one
// - Bit 1 plus pull-down, reset one
// - Bit 0 ID pull-up and sampler
`timescale 1ns/10ps
`include "otg_control_consts.svh"

module otg_control_register
  import otg_control_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  // Register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [5:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  // Bus power sensing
  input  wire logic       comparator_valid_i,
  input  wire logic       external_fault_i,
  output logic            bus_power_valid_o,
  // Bus power control
  output logic            power_switch_out_n_o,
  output logic            bus_power_drive_o,
  output logic            bus_power_charge_o,
  output logic            bus_power_discharge_o,
  // Line resistors
  output logic            minus_line_pulldown_o,
  output logic            plus_line_pulldown_o,
  output logic            id_line_pullup_sample_o
);

  // Reset value leaves both data-line pull-downs on so an idle host sees SE0
  localparam reg_byte_t RESET_BYTE = `OTG_RESET_VALUE;

  // Stored register and its next value
  reg_byte_t    otg_control_r;
  reg_byte_t    otg_control_nxt;
  access_kind_t kind;

  // Read port
  reg_byte_t    rdata_r;
  reg_byte_t    rdata_nxt;
  logic         rvalid_r;
  logic         rvalid_nxt;

  // Bus power sensing
  logic         valid_r;
  logic         valid_nxt;

  // Bus power controls, one flop each so no pin sees a gate
  logic         switch_n_r;
  logic         switch_n_nxt;
  logic         drive_r;
  logic         drive_nxt;
  logic         charge_r;
  logic         charge_nxt;
  logic         discharge_r;
  logic         discharge_nxt;

  // Line resistor controls
  logic         minus_pd_r;
  logic         minus_pd_nxt;
  logic         plus_pd_r;
  logic         plus_pd_nxt;
  logic         id_line_pullup_sample_r;
  logic         id_line_pullup_sample_nxt;

  // Unmapped addresses decode to no access at all
  function automatic access_kind_t decode(input reg_addr_t a);
    case (a)
      `OTG_ADDR_WRITE: decode = ACC_WRITE;
      `OTG_ADDR_SET:   decode = ACC_SET;
      `OTG_ADDR_CLEAR: decode = ACC_CLEAR;
      default:         decode = ACC_NONE;
    endcase
  endfunction : decode

  // Applies one write of the given kind to the current value
  function automatic reg_byte_t merge_access(input access_kind_t k, input reg_byte_t cur, input reg_byte_t data);
    case (k)
      ACC_WRITE: merge_access = data;
      ACC_SET:   merge_access = cur | data;
      ACC_CLEAR: merge_access = cur & ~data;
      default:   merge_access = cur;
    endcase
  endfunction : merge_access

  // Register group
  always_comb begin
    kind            = decode(reg_addr_i);
    otg_control_nxt = otg_control_r;
    if (reg_wr_i) begin
      otg_control_nxt = merge_access(kind, otg_control_r, reg_wdata_i);
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      otg_control_r <= RESET_BYTE;
    end else begin
      otg_control_r <= otg_control_nxt;
    end
  end

  // Read group: any of the three addresses reads the register, others read zero.
  // A read in the same cycle as a write returns the old value.
  always_comb begin
    rvalid_nxt = reg_rd_i;
    rdata_nxt  = 8'h00;
    if (reg_rd_i && (decode(reg_addr_i) != ACC_NONE)) begin
      rdata_nxt = otg_control_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Sensing group: the source follows the stored select bit, one cycle late.
  // The extra cycle keeps the indicator glitch-free when the select flips.
  always_comb begin
    if (otg_control_r[`OTG_BIT_EXT_FAULT]) begin
      valid_nxt = external_fault_i;
    end else begin
      valid_nxt = comparator_valid_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // Power group: taken from the next register value so pins move with the register.
  // No interlock between charge and discharge; the link owns that sequencing
  always_comb begin
    switch_n_nxt  = ~otg_control_nxt[`OTG_BIT_EXT_SUPPLY];
    drive_nxt     = otg_control_nxt[`OTG_BIT_DRIVE];
    charge_nxt    = otg_control_nxt[`OTG_BIT_CHARGE];
    discharge_nxt = otg_control_nxt[`OTG_BIT_DISCHARGE];
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      switch_n_r  <= ~RESET_BYTE[`OTG_BIT_EXT_SUPPLY];
      drive_r     <= RESET_BYTE[`OTG_BIT_DRIVE];
      charge_r    <= RESET_BYTE[`OTG_BIT_CHARGE];
      discharge_r <= RESET_BYTE[`OTG_BIT_DISCHARGE];
    end else begin
      switch_n_r  <= switch_n_nxt;
      drive_r     <= drive_nxt;
      charge_r    <= charge_nxt;
      discharge_r <= discharge_nxt;
    end
  end

  // Resistor group
  always_comb begin
    minus_pd_nxt  = otg_control_nxt[`OTG_BIT_MINUS_PD];
    plus_pd_nxt   = otg_control_nxt[`OTG_BIT_PLUS_PD];
    id_line_pullup_sample_nxt = otg_control_nxt[`OTG_BIT_ID_LINE_PULLUP_SAMPLE];
  end

  // Clearing the ID sampler bit is the power-saving setting
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      minus_pd_r  <= RESET_BYTE[`OTG_BIT_MINUS_PD];
      plus_pd_r   <= RESET_BYTE[`OTG_BIT_PLUS_PD];
      id_line_pullup_sample_r <= RESET_BYTE[`OTG_BIT_ID_LINE_PULLUP_SAMPLE];
    end else begin
      minus_pd_r  <= minus_pd_nxt;
      plus_pd_r   <= plus_pd_nxt;
      id_line_pullup_sample_r <= id_line_pullup_sample_nxt;
    end
  end

  // Every output comes straight from a flop
  assign reg_rdata_o             = rdata_r;
  assign reg_rvalid_o            = rvalid_r;
  assign bus_power_valid_o       = valid_r;

  assign power_switch_out_n_o    = switch_n_r;
  assign bus_power_drive_o       = drive_r;
  assign bus_power_charge_o      = charge_r;
  assign bus_power_discharge_o   = discharge_r;

  assign minus_line_pulldown_o   = minus_pd_r;
  assign plus_line_pulldown_o    = plus_pd_r;
  assign id_line_pullup_sample_o = id_line_pullup_sample_r;

  // The two registered read-port outputs, the sensing output and seven control pins
  // all reset asynchronously with the register itself.

endmodule : otg_control_register

/* testbench/otg_control_assertions.sv */
// Port checker for the OTG control register
`timescale 1ns/10ps
module otg_control_assertions(input logic clk_sys_i, nrst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, comparator_valid_i,
  external_fault_i, bus_power_valid_o, power_switch_out_n_o, bus_power_drive_o, bus_power_charge_o,
  bus_power_discharge_o, minus_line_pulldown_o, plus_line_pulldown_o, id_line_pullup_sample_o,
  input logic [5:0] reg_addr_i, input logic [7:0] reg_wdata_i, reg_rdata_o);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire [6:0] q = {!power_switch_out_n_o, bus_power_drive_o, bus_power_charge_o, bus_power_discharge_o,
    minus_line_pulldown_o, plus_line_pulldown_o, id_line_pullup_sample_o};
  wire w = reg_wr_i && reg_addr_i == 6'h0A, s = reg_wr_i && reg_addr_i == 6'h0B, c = reg_wr_i && reg_addr_i == 6'h0C;
  logic ext_sel;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) ext_sel <= 1'b0;
    else if (w) ext_sel <= reg_wdata_i[7];
    else if (s && reg_wdata_i[7]) ext_sel <= 1'b1;
    else if (c && reg_wdata_i[7]) ext_sel <= 1'b0;
  end
  a_reset_val: assert property ($rose(nrst_i) |-> q == 7'h06) else $error("reset");
  a_plain_wr: assert property (w |=> q == $past(reg_wdata_i[6:0])) else $error("write");
  a_set_bits: assert property (s |=> q == ($past(q) | $past(reg_wdata_i[6:0]))) else $error("set");
  a_clr_bits: assert property (c |=> q == ($past(q) & ~$past(reg_wdata_i[6:0]))) else $error("clear");
  a_hold_val: assert property (!(w || s || c) |=> $stable(q)) else $error("hold");
  a_rd_pulse: assert property (reg_rvalid_o == $past(reg_rd_i)) else $error("rvalid");
  a_rd_data: assert property (reg_rd_i && !reg_wr_i && reg_addr_i inside {[6'h0A:6'h0C]}
    |=> reg_rdata_o[6:0] == $past(q)) else $error("rdata");
  a_rd_sel: assert property (reg_rd_i && !reg_wr_i && reg_addr_i inside {[6'h0A:6'h0C]}
    |=> reg_rdata_o[7] == $past(ext_sel)) else $error("rdata select");
  a_rd_none: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata idle");
  a_sense_pick: assert property (1'b1
    |=> bus_power_valid_o == $past(ext_sel ? external_fault_i : comparator_valid_i)) else $error("sense");
  c_set: cover property (s);
  c_clr: cover property (c);
  c_rd: cover property (reg_rd_i);
endmodule : otg_control_assertions
bind otg_control_register otg_control_assertions i_otg_control_assertions(.*);

/* testbench/link_model.sv */
// Link-side model issuing one register access at a time
`timescale 1ns/10ps
module link_model(input logic clk_sys_i, output logic reg_wr_i = 0, reg_rd_i = 0,
  output logic [5:0] reg_addr_i = 0, output logic [7:0] reg_wdata_i = 0);
  // An idle edge before each access keeps strobe edges apart
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1 {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
    @(posedge clk_sys_i) #1 {reg_wr_i, reg_rd_i} <= 2'b00;
  endtask : acc
endmodule : link_model

/* testbench/tb.sv */
// Self-checking bench for the OTG control register
`timescale 1ns/10ps
module tb;
  logic clk_sys_i = 0, nrst_i = 0, comparator_valid_i = 0, external_fault_i = 0, reg_wr_i, reg_rd_i, reg_rvalid_o,
    bus_power_valid_o, power_switch_out_n_o, bus_power_drive_o, bus_power_charge_o, bus_power_discharge_o,
    minus_line_pulldown_o, plus_line_pulldown_o, id_line_pullup_sample_o;
  logic [5:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  int bad_count = 0, compares = 0, cyc = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  link_model i_link_model(.*);
  otg_control_register i_otg_control_register(.*);
  task automatic chk(string n, logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic rd(logic [5:0] a, logic [7:0] e, string n);
    i_link_model.acc(0, a, 8'h00);
    chk("rvalid", 8'h01, reg_rvalid_o);
    chk(n, e, reg_rdata_o);
  endtask : rd
  task automatic idle_outputs;
    chk("switch idle", 8'h01, power_switch_out_n_o);
    chk("drive idle", 8'h00, bus_power_drive_o);
    chk("charge idle", 8'h00, bus_power_charge_o);
    chk("discharge idle", 8'h00, bus_power_discharge_o);
    chk("minus pd idle", 8'h01, minus_line_pulldown_o);
    chk("plus pd idle", 8'h01, plus_line_pulldown_o);
    chk("id_line_pullup_sample idle", 8'h00, id_line_pullup_sample_o);
  endtask : idle_outputs
  task automatic t_reset;
    i_link_model.acc(1, 6'h0A, 8'hF9);
    chk("id_line_pullup_sample", 8'h01, id_line_pullup_sample_o);
    chk("minus pd off", 8'h00, minus_line_pulldown_o);
    @(posedge clk_sys_i) #1 nrst_i = 0;
    #1 idle_outputs;
    repeat (2) @(posedge clk_sys_i);
    #1 nrst_i = 1;
    rd(6'h0A, 8'h06, "reset again");
  endtask : t_reset
  task automatic t_write;
    i_link_model.acc(1, 6'h0A, 8'hFF);
    chk("switch", 8'h00, power_switch_out_n_o);
    chk("drive", 8'h01, bus_power_drive_o);
    chk("charge", 8'h01, bus_power_charge_o);
    rd(6'h0C, 8'hFF, "read");
    i_link_model.acc(1, 6'h0D, 8'h00);
    rd(6'h0D, 8'h00, "unmapped");
  endtask : t_write
  task automatic t_pulse;
    i_link_model.acc(1, 6'h0A, 8'h00);
    i_link_model.acc(1, 6'h0B, 8'h08);
    chk("discharge", 8'h01, bus_power_discharge_o);
    i_link_model.acc(1, 6'h0C, 8'h08);
    i_link_model.acc(1, 6'h0B, 8'h10);
    rd(6'h0A, 8'h10, "charge");
  endtask : t_pulse
  task automatic t_sense;
    external_fault_i = 1;
    i_link_model.acc(1, 6'h0B, 8'h80);
    rd(6'h0A, 8'h90, "select");
    chk("fault pin", 8'h01, bus_power_valid_o);
    i_link_model.acc(1, 6'h0C, 8'h80);
    rd(6'h0A, 8'h10, "comparator");
    chk("comparator", 8'h00, bus_power_valid_o);
  endtask : t_sense
  task automatic give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      bad_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1 nrst_i = 1;
    idle_outputs;
    rd(6'h0A, 8'h06, "reset");
    t_write;
    t_pulse;
    t_sense;
    t_reset;
    give_verdict;
  end
endmodule : tb
